// >>> core/acsm_top.sv
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// ****************************************
// moving average filter
// ****************************************
module acsm_filter #(
   parameter int W = 13,
   parameter int DEPTH = 30
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic sample_i,
   input wire logic [4:0] len_i,
   input wire logic signed [W-1:0] din_i,
   output logic signed [W-1:0] avg_o
);
   logic signed [W-1:0] hist_r [DEPTH];
   logic signed [W+5:0] sum_r;
   logic [4:0] len_r;
   logic signed [W+5:0] sum_nxt;
   always_comb
   begin
      sum_nxt = sum_r + W'(din_i) - hist_r[len_r - 5'h01];
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         len_r <= 5'h01;
         sum_r <= '0;
         for (int i = 0; i < DEPTH; i++) hist_r[i] <= '0;
      end
      else if (len_i != len_r)
      begin
         len_r <= len_i;
         sum_r <= '0;
         for (int i = 0; i < DEPTH; i++) hist_r[i] <= '0;
      end
      else if (sample_i)
      begin
         sum_r <= sum_nxt;
         hist_r[0] <= din_i;
         for (int i = 1; i < DEPTH; i++) hist_r[i] <= hist_r[i-1];
      end
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         avg_o <= '0;
      else
         avg_o <= W'(sum_r / $signed({1'b0, len_r}));
   end
endmodule : acsm_filter
// ****************************************
// top
// ****************************************
module acsm_top #(
   parameter int FM_ACC_W = 24
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_i,
   input wire logic [11:0] voltage_input_i,
   input wire logic [11:0] current_command_input_i,
   input wire logic signed [11:0] bipolar_trim_input_i,
   input wire logic analog_type_select_input_i,
   input wire logic [11:0] out_freq_i,
   input wire logic [11:0] out_current_i,
   input wire logic [11:0] out_torque_i,
   input wire logic [11:0] out_voltage_i,
   input wire logic [11:0] in_power_i,
   input wire logic [11:0] thermal_load_i,
   input wire logic [11:0] lad_freq_i,
   output logic signed [13:0] freq_cmd_o,
   output logic forward_o,
   output logic reverse_o,
   output logic monitor_pulse_output_o
);
   logic [31:0] ctrl_r, scale_r, mon_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   logic [1:0] src, type_sel, bip_sel;
   logic atmap, o2mode, trim_en, bip;
   logic [4:0] filt;
   logic [2:0] msel, mode;
   logic [7:0] gain;
   acsm_pkg::acsm_sel_type main_sel;
   logic signed [12:0] v_f, c_f, t_f;
   logic [23:0] v_prod;
   logic signed [13:0] v_scaled, main_val, cmd_nxt;
   logic signed [14:0] total;
   logic [23:0] v_quot;
   logic [11:0] mon_q, duty_nxt, duty_r, pwm_cnt_r;
   logic [19:0] duty_prod;
   logic [FM_ACC_W-1:0] fm_acc_r;
   logic [31:0] wmask, status;
   assign src = ctrl_r[acsm_pkg::SRC_LSB +: 2];
   assign type_sel = ctrl_r[acsm_pkg::TYPE_LSB +: 2];
   assign bip_sel = ctrl_r[acsm_pkg::BIP_LSB +: 2];
   assign atmap = ctrl_r[acsm_pkg::ATMAP_BIT];
   assign filt = ctrl_r[acsm_pkg::FILT_LSB +: 5];
   assign msel = mon_r[acsm_pkg::MSEL_LSB +: 3];
   assign gain = mon_r[acsm_pkg::GAIN_LSB +: 8];
   assign mode = mon_r[acsm_pkg::MODE_LSB +: 3];
   // ****************************************
   // register bus
   // ****************************************
   always_comb
   begin
      for (int i = 0; i < 4; i++) wmask[8*i +: 8] = {8{wstrb_r[i]}};
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= acsm_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            s_axi_awready <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            s_axi_wready <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == acsm_pkg::CTRL_OFS ||
                awaddr_r == acsm_pkg::SCALE_OFS ||
                awaddr_r == acsm_pkg::MON_OFS)
               s_axi_bresp <= acsm_pkg::RESP_OKAY;
            else
               s_axi_bresp <= acsm_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // both halves of a write held and no answer pending
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_r <= acsm_pkg::CTRL_RST;
         scale_r <= acsm_pkg::SCALE_RST;
         mon_r <= acsm_pkg::MON_RST;
      end
      else if (wr_go)
      begin
         if (awaddr_r == acsm_pkg::CTRL_OFS)
         begin
            ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask & 32'h0000_1f7f);
            if (wstrb_r[1] && wdata_r[12:8] < acsm_pkg::FILT_MIN)
               ctrl_r[acsm_pkg::FILT_LSB +: 5] <= acsm_pkg::FILT_MIN;
            else if (wstrb_r[1] && wdata_r[12:8] > acsm_pkg::FILT_MAX)
               ctrl_r[acsm_pkg::FILT_LSB +: 5] <= acsm_pkg::FILT_MAX;
         end
         else if (awaddr_r == acsm_pkg::SCALE_OFS)
         begin
            scale_r <= (scale_r & ~wmask) |
                       (wdata_r & wmask & 32'h0000_0fff);
            if (wstrb_r[1:0] != 2'h0 && (wdata_r[11:0] & wmask[11:0]) == 0 &&
                (scale_r[11:0] & ~wmask[11:0]) == 0)
               scale_r <= 32'h0000_0001;
         end
         else if (awaddr_r == acsm_pkg::MON_OFS)
            mon_r <= (mon_r & ~wmask) | (wdata_r & wmask & 32'h0007_ff07);
      end
   end
   assign status = {12'h000, main_sel, trim_en, bip, reverse_o, forward_o,
                    freq_cmd_o};
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= acsm_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= acsm_pkg::RESP_OKAY;
         if (s_axi_araddr == acsm_pkg::CTRL_OFS)
            s_axi_rdata <= ctrl_r;
         else if (s_axi_araddr == acsm_pkg::SCALE_OFS)
            s_axi_rdata <= scale_r;
         else if (s_axi_araddr == acsm_pkg::MON_OFS)
            s_axi_rdata <= mon_r;
         else if (s_axi_araddr == acsm_pkg::STATUS_OFS)
            s_axi_rdata <= status;
         else
         begin
            s_axi_rdata <= '0;
            s_axi_rresp <= acsm_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
   // ****************************************
   // input filters
   // ****************************************
   acsm_filter #(.W(13), .DEPTH(30)) u_filt_v (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sample_i(sample_i),
      .len_i(filt), .din_i($signed({1'b0, voltage_input_i})), .avg_o(v_f)
   );
   acsm_filter #(.W(13), .DEPTH(30)) u_filt_c (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sample_i(sample_i),
      .len_i(filt), .din_i($signed({1'b0, current_command_input_i})),
      .avg_o(c_f)
   );
   acsm_filter #(.W(13), .DEPTH(30)) u_filt_t (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sample_i(sample_i),
      .len_i(filt), .din_i(13'(bipolar_trim_input_i)), .avg_o(t_f)
   );
   // ****************************************
   // input selection
   // ****************************************
   always_comb
   begin
      o2mode = 1'b0;
      trim_en = 1'b0;
      bip = 1'b0;
      main_sel = acsm_pkg::SEL_O;
      if (!atmap)
      begin
         trim_en = (bip_sel == acsm_pkg::BIP_01 ||
                    bip_sel == acsm_pkg::BIP_02);
         bip = (bip_sel == acsm_pkg::BIP_00 ||
                bip_sel == acsm_pkg::BIP_02);
         if (bip_sel == acsm_pkg::BIP_00)
            main_sel = acsm_pkg::SEL_O2;
         else
            main_sel = acsm_pkg::SEL_SUM;
      end
      else
      begin
         o2mode = type_sel == acsm_pkg::TYPE_O2 &&
                  analog_type_select_input_i;
         if (o2mode)
         begin
            main_sel = acsm_pkg::SEL_O2;
            bip = 1'b1;
         end
         else
         begin
            main_sel = analog_type_select_input_i ? acsm_pkg::SEL_OI :
                       acsm_pkg::SEL_O;
            trim_en = (bip_sel == acsm_pkg::BIP_01 ||
                       bip_sel == acsm_pkg::BIP_02);
            bip = bip_sel == acsm_pkg::BIP_02;
         end
      end
   end
   always_comb
   begin
      v_prod = 24'(v_f[11:0]) * 24'(acsm_pkg::FULL_CODE);
      v_quot = v_prod / {12'h000, scale_r[11:0]};
      // clamp on the full quotient, small spans overflow 14 bits
      if (v_quot > 24'(acsm_pkg::CMD_MAX))
         v_scaled = acsm_pkg::CMD_MAX;
      else
         v_scaled = 14'(v_quot);
      case (main_sel)
         acsm_pkg::SEL_O: main_val = v_scaled;
         acsm_pkg::SEL_OI: main_val = 14'(c_f);
         acsm_pkg::SEL_O2: main_val = 14'(t_f) <<< 1;
         default: main_val = v_scaled + 14'(c_f);
      endcase
      total = 15'(main_val) + (trim_en ? 15'(t_f) <<< 1 : 15'sh0000);
      if (src != acsm_pkg::SRC_ANALOG)
         cmd_nxt = 14'sh0000;
      else if (!bip && total < 0)
         cmd_nxt = 14'sh0000;
      else if (total > acsm_pkg::CMD_MAX)
         cmd_nxt = acsm_pkg::CMD_MAX;
      else if (total < -acsm_pkg::CMD_MAX)
         cmd_nxt = -acsm_pkg::CMD_MAX;
      else
         cmd_nxt = 14'(total);
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         freq_cmd_o <= '0;
         forward_o <= 1'b0;
         reverse_o <= 1'b0;
      end
      else
      begin
         freq_cmd_o <= cmd_nxt;
         forward_o <= cmd_nxt > 0;
         reverse_o <= cmd_nxt < 0;
      end
   end
   // ****************************************
   // monitor output
   // ****************************************
   always_comb
   begin
      case (msel)
         acsm_pkg::MON_CUR: mon_q = out_current_i;
         acsm_pkg::MON_TRQ: mon_q = (mode >= acsm_pkg::MODE_SLV &&
                                     mode <= acsm_pkg::MODE_VEC) ?
                                    out_torque_i : 12'h000;
         acsm_pkg::MON_VOLT: mon_q = out_voltage_i;
         acsm_pkg::MON_PWR: mon_q = in_power_i;
         acsm_pkg::MON_THERM: mon_q = thermal_load_i;
         acsm_pkg::MON_FREQ: mon_q = out_freq_i;
         acsm_pkg::MON_FM: mon_q = out_freq_i;
         default: mon_q = lad_freq_i;
      endcase
      duty_prod = mon_q * gain;
      duty_nxt = 12'(duty_prod / acsm_pkg::GAIN_FULL);
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         duty_r <= '0;
         pwm_cnt_r <= '0;
         fm_acc_r <= '0;
      end
      else
      begin
         duty_r <= duty_nxt;
         pwm_cnt_r <= pwm_cnt_r + 12'h001;
         fm_acc_r <= fm_acc_r + FM_ACC_W'(out_freq_i);
      end
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         monitor_pulse_output_o <= 1'b0;
      else if (msel == acsm_pkg::MON_FM)
         monitor_pulse_output_o <= fm_acc_r[FM_ACC_W-1];
      else
         monitor_pulse_output_o <= pwm_cnt_r < duty_r;
   end
   // ****************************************
   // checks
   // ****************************************
   default clocking cb_sys @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_wr_ready;
      wr_go;
   endsequence
   sequence s_wr_resp;
      ##1 s_axi_bvalid && s_axi_awready && s_axi_wready;
   endsequence
   a_filter_range: assert property (
      filt >= acsm_pkg::FILT_MIN && filt <= acsm_pkg::FILT_MAX)
      else $error("filter setting out of range");
   a_write_resp: assert property (
      s_wr_ready |-> s_wr_resp)
      else $error("write response missing");
   a_source_gate: assert property (
      src != acsm_pkg::SRC_ANALOG |=> freq_cmd_o == 14'sh0000)
      else $error("command not zero without analog source");
   a_unipolar_clamp: assert property (
      !bip |=> !reverse_o && freq_cmd_o >= 0)
      else $error("negative command while reverse barred");
   a_dir_sign: assert property (
      (freq_cmd_o > 0) == forward_o && (freq_cmd_o < 0) == reverse_o)
      else $error("direction does not match sign");
   a_at_voltage: assert property (
      atmap && !analog_type_select_input_i |-> main_sel == acsm_pkg::SEL_O)
      else $error("voltage input not chosen");
   a_at_current: assert property (
      atmap && analog_type_select_input_i && type_sel != acsm_pkg::TYPE_O2
      |-> main_sel == acsm_pkg::SEL_OI)
      else $error("current input not chosen");
   a_unmapped_o2: assert property (
      !atmap |-> (main_sel == acsm_pkg::SEL_O2) ==
      (bip_sel == acsm_pkg::BIP_00) && bip == (bip_sel != 2'h1 &&
      bip_sel != 2'h3))
      else $error("unmapped selection wrong");
   a_trim_enable: assert property (
      atmap && !o2mode |-> trim_en == (bip_sel == acsm_pkg::BIP_01 ||
      bip_sel == acsm_pkg::BIP_02))
      else $error("trim enable wrong");
   a_torque_gate: assert property (
      msel == acsm_pkg::MON_TRQ && mode < acsm_pkg::MODE_SLV |=> duty_r == 0)
      else $error("torque shown outside vector modes");
   a_fm_track: assert property (
      msel == acsm_pkg::MON_FM |=>
      monitor_pulse_output_o == $past(fm_acc_r[FM_ACC_W-1]))
      else $error("FM output not from accumulator");
endmodule : acsm_top

// >>> core/acsm_pkg.sv
package acsm_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SCALE_OFS = 8'h04;
   localparam logic [7:0] MON_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam int SRC_LSB = 0;
   localparam int TYPE_LSB = 2;
   localparam int BIP_LSB = 4;
   localparam int ATMAP_BIT = 6;
   localparam int FILT_LSB = 8;
   localparam int MSEL_LSB = 0;
   localparam int GAIN_LSB = 8;
   localparam int MODE_LSB = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0141;
   localparam logic [31:0] SCALE_RST = 32'h0000_0fff;
   localparam logic [31:0] MON_RST = 32'h0000_ff00;
   // ****************************************
   // codes and limits
   // ****************************************
   localparam logic [4:0] FILT_MIN = 5'h01;
   localparam logic [4:0] FILT_MAX = 5'h1e;
   localparam logic [1:0] SRC_ANALOG = 2'h1;
   localparam logic [1:0] TYPE_O2 = 2'h1;
   localparam logic [1:0] BIP_00 = 2'h0;
   localparam logic [1:0] BIP_01 = 2'h1;
   localparam logic [1:0] BIP_02 = 2'h2;
   localparam logic [2:0] MON_FREQ = 3'h0;
   localparam logic [2:0] MON_CUR = 3'h1;
   localparam logic [2:0] MON_TRQ = 3'h2;
   localparam logic [2:0] MON_FM = 3'h3;
   localparam logic [2:0] MON_VOLT = 3'h4;
   localparam logic [2:0] MON_PWR = 3'h5;
   localparam logic [2:0] MON_THERM = 3'h6;
   localparam logic [2:0] MODE_SLV = 3'h3;
   localparam logic [2:0] MODE_VEC = 3'h5;
   localparam logic [7:0] GAIN_FULL = 8'hff;
   localparam logic signed [13:0] CMD_MAX = 14'sh0fff;
   localparam logic [11:0] FULL_CODE = 12'hfff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {SEL_O, SEL_OI, SEL_O2, SEL_SUM} acsm_sel_type;
endpackage : acsm_pkg

// >>> dv/acsm_src_model.sv
`timescale 1ns/1ns
// ****************************************
// analog source sampler and monitor meter
// ****************************************
module acsm_src_model (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] period_i,
   input wire logic pulse_i,
   input wire logic clr_i,
   output logic sample_o,
   output int hi_o,
   output int rise_o
);
   logic [3:0] cnt_r;
   logic last_r;
   // converter strobe, slower when period grows
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_r <= 4'h0;
         sample_o <= 1'b0;
      end
      else
      begin
         cnt_r <= (cnt_r >= period_i) ? 4'h0 : cnt_r + 4'h1;
         sample_o <= (cnt_r == 4'h0);
      end
   end
   // meter: high time and rising edges since clear
   always_ff @(posedge sys_clk_i)
   begin
      last_r <= pulse_i;
      if (clr_i)
      begin
         hi_o <= 0;
         rise_o <= 0;
      end
      else
      begin
         hi_o <= hi_o + int'(pulse_i);
         rise_o <= rise_o + int'(pulse_i && !last_r);
      end
   end
endmodule : acsm_src_model

// >>> dv/acsm_tb_top.sv
`timescale 1ns/1ns
module acsm_tb_top;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, fwd, rev, mon, smp;
   logic [1:0] bresp, rresp, r;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [11:0] v = 12'h000, c = 12'h000, t = 12'h000;
   logic [11:0] q[8] = '{default: 12'h000};
   logic atsel = 1'b0, clr = 1'b1;
   logic signed [13:0] cmd;
   logic [15:0] seed = 16'ha0a4;
   int hi, rise, n_errors = 0, total_checks = 0;
   int m, b, ty, a, s, k, e, g;
   int fq[$];
   always #5 sys_clk = ~sys_clk;
   acsm_top #(.FM_ACC_W(12)) u_dut (.sys_clk_i(sys_clk), .nrst_i(nrst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sample_i(smp), .voltage_input_i(v),
      .current_command_input_i(c), .bipolar_trim_input_i(t),
      .analog_type_select_input_i(atsel), .out_freq_i(q[0]),
      .out_current_i(q[1]), .out_torque_i(q[2]), .out_voltage_i(q[4]),
      .in_power_i(q[5]), .thermal_load_i(q[6]), .lad_freq_i(q[7]),
      .freq_cmd_o(cmd), .forward_o(fwd), .reverse_o(rev),
      .monitor_pulse_output_o(mon));
   acsm_src_model u_src (.sys_clk_i(sys_clk), .nrst_i(nrst),
      .period_i(4'h3), .pulse_i(mon), .clr_i(clr), .sample_o(smp),
      .hi_o(hi), .rise_o(rise));
   // ****************************************
   // helpers
   // ****************************************
   function logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   function int model(int bp, int tp, int mp, int at, int vs, int cc, int tr);
      int mm;
      logic o2, tu, bok;
      o2 = mp ? (tp == 1 && at) : (bp == 0);
      mm = o2 ? tr : (!mp ? vs + cc : (at ? cc : vs));
      tu = !o2 && (bp == 1 || bp == 2);
      bok = o2 || bp == 2;
      mm = mm + (tu ? tr : 0);
      mm = mm > 4095 ? 4095 : (mm < -4095 ? -4095 : mm);
      return (!bok && mm < 0) ? 0 : mm;
   endfunction : model
   task chk(input logic [31:0] sn, input logic [31:0] ex);
      total_checks++;
      if (sn !== ex)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, sn, ex);
      end
   endtask : chk
   task axw(input logic [7:0] ad, input logic [31:0] dd);
      @(posedge sys_clk);
      awaddr <= ad;
      wdata <= dd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : axw
   task axr(input logic [7:0] ad);
      @(posedge sys_clk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : axr
   task summarize;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      n_errors++;
      summarize();
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      axr(acsm_pkg::CTRL_OFS);
      chk(d, acsm_pkg::CTRL_RST);
      axr(acsm_pkg::SCALE_OFS);
      chk(d, acsm_pkg::SCALE_RST);
      axr(acsm_pkg::MON_OFS);
      chk(d, acsm_pkg::MON_RST);
      axr(8'h10);
      chk({30'h0, r}, {30'h0, acsm_pkg::RESP_SLVERR});
      axw(8'h14, 32'hffff_ffff);
      chk({30'h0, r}, {30'h0, acsm_pkg::RESP_SLVERR});
      for (k = 0; k < 2; k++)
      begin
         axw(acsm_pkg::CTRL_OFS, k ? 32'h1f41 : 32'h0041);
         axr(acsm_pkg::CTRL_OFS);
         chk({27'h0, d[12:8]}, k ? 32'd30 : 32'd1);
      end
      $display("test registers done");
      v <= 12'h400;
      c <= 12'h300;
      t <= 12'hd00;
      for (m = 0; m < 2; m++)
         for (b = 0; b < 4; b++)
            for (ty = 0; ty < 2; ty++)
               for (a = 0; a < 2; a++)
               begin
                  atsel <= a[0];
                  axw(acsm_pkg::CTRL_OFS, {19'h0, 5'h01, 1'b0, m[0], b[1:0],
                     ty[1:0], acsm_pkg::SRC_ANALOG});
                  repeat (20) @(posedge sys_clk);
                  e = model(b, ty, m, a, 'h400, 'h300, -'h600);
                  chk(int'(cmd), e);
                  chk({30'h0, fwd, rev}, {30'h0, e > 0, e < 0});
                  axr(acsm_pkg::STATUS_OFS);
                  chk({16'h0, d[15:0]}, {16'h0, e < 0, e > 0, 14'(e)});
               end
      $display("test selection done");
      atsel <= 1'b0;
      v <= 12'h000;
      axw(acsm_pkg::CTRL_OFS, 32'h0000_0441);
      repeat (40) @(posedge sys_clk);
      for (k = 0; k < 10; k++)
      begin
         @(posedge sys_clk iff smp);
         fq.push_back(int'(v));
         if (fq.size() > 4) void'(fq.pop_front());
         seed = lfsr(seed);
         v <= seed[11:0];
         repeat (3) @(posedge sys_clk);
         #1 chk(32'(int'(cmd)), 32'(fq.sum() / 4));
      end
      $display("test filter done");
      axw(acsm_pkg::CTRL_OFS, 32'h0000_0141);
      axw(acsm_pkg::SCALE_OFS, 32'h0000_0800);
      for (k = 0; k < 2; k++)
      begin
         v <= k ? 12'hc00 : 12'h400;
         repeat (20) @(posedge sys_clk);
         chk(32'(int'(cmd)), k ? 32'd4095 : 32'd2047);
      end
      $display("test scale done");
      for (s = 0; s < 9; s++)
      begin
         if (s == 3) continue;
         for (k = 0; k < 8; k++)
         begin
            seed = lfsr(seed);
            q[k] <= seed[11:0];
         end
         seed = lfsr(seed);
         g = int'(seed[7:0]);
         axw(acsm_pkg::MON_OFS, {13'h0, s == 8 ? 3'h0 : acsm_pkg::MODE_VEC,
            g[7:0], 5'h0, s == 8 ? acsm_pkg::MON_TRQ : s[2:0]});
         repeat (4100) @(posedge sys_clk);
         clr <= 1'b1;
         @(posedge sys_clk);
         clr <= 1'b0;
         repeat (4096) @(posedge sys_clk);
         e = (s == 8) ? 0 : int'(q[s]) * g / 255;
         #1 chk(32'(hi), 32'(e));
      end
      $display("test pulse width done");
      q[0] <= 12'h100;
      axw(acsm_pkg::MON_OFS, {13'h0, acsm_pkg::MODE_VEC, 8'h00, 5'h0,
         acsm_pkg::MON_FM});
      repeat (100) @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      repeat (4096) @(posedge sys_clk);
      #1 chk(32'(rise >= 255 && rise <= 257), 32'd1);
      $display("test frequency mode done");
      summarize();
   end
endmodule : acsm_tb_top
